// *** sim/slbc_remote_model.sv ***
// behavioural remote serializer sending the switching test pattern
`timescale 1ns/100ps
`default_nettype none
module slbc_remote_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // requests from the checker
    input wire logic remote_wake,
    input wire logic remote_selftest,
    input wire logic frame_ready,
    // scenario knobs
    input wire logic inject,
    input wire logic stall,
    input wire logic drop_lock,
    // link side
    output logic remote_active,
    output logic backchannel_ok,
    output logic rx_lock,
    output logic frame_valid,
    output slbc_pkg::slbc_frame_type frame_in,
    output int err_frames
);
    import slbc_pkg::*;
    logic [3:0] warm;
    logic [1:0] beat;
    logic sticky;
    logic locked;
    logic junk;
    assign backchannel_ok = remote_active;
    assign rx_lock = locked && !drop_lock;
    assign frame_valid = remote_selftest && warm == 4'hF && !stall;
    // idle words toggle so stale data is never mistaken for a beat
    assign frame_in = frame_valid ? slbc_frame_type'({beat == 2'h3, inject})
                                  : slbc_frame_type'({junk, ~junk});
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {remote_active, locked, sticky, junk, warm, beat} <= '0;
            err_frames <= 0;
        end else begin
            junk <= ~junk;
            if (remote_wake) remote_active <= 1'b1;
            if (drop_lock) locked <= 1'b0;
            else if (warm >= 4'h8) locked <= 1'b1;
            if (!(remote_selftest && remote_active)) warm <= 4'h0;
            else if (warm != 4'hF) warm <= warm + 4'h1;
            if (frame_valid && frame_ready) begin
                beat <= beat + 2'h1;
                sticky <= (beat == 2'h3) ? 1'b0 : (sticky | inject);
                if (beat == 2'h3 && (sticky || inject)) err_frames <= err_frames + 1;
            end
        end
    end
endmodule : slbc_remote_model
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench of the self-test checker
`include "slbc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
    import slbc_pkg::*;
    typedef struct packed {logic [1:0] pins; logic [7:0] ctl; logic [1:0] src;} slbc_row_type;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic selftest_enable = 1'b0;
    logic clock_select_pin0 = 1'b0;
    logic clock_select_pin1 = 1'b0;
    logic inject = 1'b0;
    logic stall = 1'b0;
    logic drop_lock = 1'b0;
    logic count_on = 1'b0;
    logic last_pin = 1'b0;
    logic w;
    slbc_reg_req_type reg_req = '0;
    slbc_frame_type frame_in;
    slbc_clksrc_type clock_source;
    logic rx_lock, remote_active, backchannel_ok, frame_valid, frame_ready;
    logic remote_wake, remote_selftest, result_pin, selftest_active, video_normal;
    logic [7:0] reg_rdata;
    int errors = 0;
    int checks_done = 0;
    int pulses = 0;
    int long_lows = 0;
    int err_frames;
    int i;
    slbc_row_type rows [6] = '{'{2'b00, 8'h00, 2'b00}, '{2'b01, 8'h00, 2'b01},
        '{2'b10, 8'h00, 2'b10}, '{2'b11, 8'h00, 2'b11}, '{2'b00, 8'h0D, 2'b11},
        '{2'b11, 8'h05, 2'b01}};
    slbc_checker slbc_checker_inst (.clk(clk), .rst_b(rst_b),
        .selftest_enable(selftest_enable), .clock_select_pin0(clock_select_pin0),
        .clock_select_pin1(clock_select_pin1), .rx_lock(rx_lock),
        .remote_active(remote_active), .backchannel_ok(backchannel_ok),
        .frame_in(frame_in), .frame_valid(frame_valid), .frame_ready(frame_ready),
        .remote_wake(remote_wake), .remote_selftest(remote_selftest),
        .result_pin(result_pin), .selftest_active(selftest_active),
        .video_normal(video_normal), .clock_source(clock_source),
        .reg_req(reg_req), .reg_rdata(reg_rdata));
    slbc_remote_model slbc_remote_model_inst (.clk(clk), .rst_b(rst_b),
        .remote_wake(remote_wake), .remote_selftest(remote_selftest),
        .frame_ready(frame_ready), .inject(inject), .stall(stall),
        .drop_lock(drop_lock), .remote_active(remote_active),
        .backchannel_ok(backchannel_ok), .rx_lock(rx_lock),
        .frame_valid(frame_valid), .frame_in(frame_in), .err_frames(err_frames));
    always #5 clk = ~clk;
    // falling edges and over-long lows of the result pin
    always @(posedge clk) begin
        last_pin <= result_pin;
        if (count_on && last_pin && !result_pin) pulses <= pulses + 1;
        if (count_on && !last_pin && !result_pin) long_lows <= long_lows + 1;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_req = '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        #1 reg_req = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 reg_req = '{a, 8'h00, 1'b0, 1'b1};
        #4 chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    task automatic wrap_up;
        if (errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        for (int r = 0; r < 6; r++) begin
            @(posedge clk);
            #1 {clock_select_pin1, clock_select_pin0} = rows[r].pins;
            wr(`SLBC_ADDR_CONTROL, rows[r].ctl);
            rd(`SLBC_ADDR_CONTROL, rows[r].ctl);
            chk({14'h0, clock_source}, {14'h0, rows[r].src});
        end
        wr(`SLBC_ADDR_CONTROL, 8'h00);
        @(posedge clk);
        #1 selftest_enable = 1'b1;
        for (i = 0; i < 20 && remote_wake !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0, remote_wake}, 16'h0001);
        chk({14'h0, selftest_active, video_normal}, 16'h0002);
        for (i = 0; i < 100 && result_pin !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0, result_pin}, 16'h0001);
        count_on = 1'b1;
        inject = 1'b1;
        repeat (1300) @(posedge clk);
        #1 inject = 1'b0;
        stall = 1'b1;
        repeat (20) @(posedge clk);
        chk(16'(pulses), 16'(err_frames));
        chk(16'(long_lows), 16'h0000);
        rd(`SLBC_ADDR_ERROR_COUNT, (err_frames > 255) ? 8'hFF : 8'(err_frames));
        @(posedge clk);
        #1 count_on = 1'b0;
        selftest_enable = 1'b0;
        repeat (3) @(posedge clk);
        chk({14'h0, result_pin, video_normal}, 16'h0001);
        repeat (30) @(posedge clk);
        chk({15'h0, result_pin}, 16'h0000);
        rd(`SLBC_ADDR_ERROR_COUNT, (err_frames > 255) ? 8'hFF : 8'(err_frames));
        @(posedge clk);
        #1 drop_lock = 1'b1;
        repeat (3) @(posedge clk);
        chk({15'h0, selftest_active}, 16'h0000);
        #1 drop_lock = 1'b0;
        stall = 1'b0;
        wr(`SLBC_ADDR_CONTROL, 8'h03);
        w = 1'b0;
        for (i = 0; i < 100 && result_pin !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            if (remote_wake === 1'b1) w = 1'b1;
        end
        chk({14'h0, w, result_pin}, 16'h0001);
        rd(`SLBC_ADDR_ERROR_COUNT, 8'h00);
        repeat (100) @(posedge clk);
        #1 stall = 1'b1;
        repeat (20) @(posedge clk);
        wr(`SLBC_ADDR_CONTROL, 8'h01);
        repeat (3) @(posedge clk);
        chk({14'h0, result_pin, video_normal}, 16'h0003);
        rd(`SLBC_ADDR_ERROR_COUNT, 8'h00);
        #1 rst_b = 1'b0;
        @(posedge clk);
        #1 chk({14'h0, result_pin, video_normal}, 16'h0001);
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        rd(`SLBC_ADDR_CONTROL, 8'h00);
        wrap_up();
    end
endmodule : tb
`default_nettype wire

// *** src/slbc_checker.sv ***
// self-test checker of the deserializer: session control, frame checking, result pin, counter
// Notes on behaviour
// - pins configure after reset; register may override
// - enable pin starts self-test mode
// - clock-select pins choose test clock source
// - wake remote serializer over back channel
// - on lock, result high and checking starts
// - errored frame pulses result low briefly
// - one low pulse per errored frame
// - after run, result shows pass or fail
// - result held until new session, reset or loss of rx_lock
// - errored-frame count readable by software
// - count kept in error count register
// - enable low stops data checking
// - final result held after enable low
// - enable low returns link to video
// - test covers forward link; back channel checked only when the remote is woken (skipped if remote_active when a session starts from idle)
`include "slbc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module slbc_checker #(
    parameter int FIFO_DEPTH = 16,
    parameter int COUNT_WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // configuration pins
    input wire logic selftest_enable,
    input wire logic clock_select_pin0,
    input wire logic clock_select_pin1,
    // link status and received frames
    input wire logic rx_lock,
    input wire logic remote_active,
    input wire logic backchannel_ok,
    input wire slbc_pkg::slbc_frame_type frame_in,
    input wire logic frame_valid,
    output logic frame_ready,
    // remote control
    output logic remote_wake,
    output logic remote_selftest,
    // result and status
    output logic result_pin,
    output logic selftest_active,
    output logic video_normal,
    output slbc_pkg::slbc_clksrc_type clock_source,
    // register port
    input wire slbc_pkg::slbc_reg_req_type reg_req,
    output logic [7:0] reg_rdata
);
    import slbc_pkg::*;
    initial begin
        if (COUNT_WIDTH < 1 || COUNT_WIDTH > 8) $error("count width must be 1..8");
    end

    logic rst_meta_b;
    logic rst_sync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // control register
    logic [7:0] selftest_control;
    wire ctl_wr = reg_req.write && reg_req.addr == `SLBC_ADDR_CONTROL;
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) selftest_control <= `SLBC_CTL_RESET;
        else if (ctl_wr) selftest_control <= reg_req.wdata;
    end
    wire use_reg = selftest_control[`SLBC_CTL_PIN_OVERRIDE];
    wire enable_req = use_reg ? selftest_control[`SLBC_CTL_ENABLE] : selftest_enable;
    wire [1:0] pin_sel = {clock_select_pin1, clock_select_pin0};
    wire [1:0] reg_sel = selftest_control[`SLBC_CTL_CLKSEL_HI:`SLBC_CTL_CLKSEL_LO];
    wire [1:0] sel_code = use_reg ? reg_sel : pin_sel;

    // session state machine
    slbc_state_type state;
    slbc_state_type next_state;
    localparam int WAKE_CYCLES = `SLBC_WAKE_CYCLES;
    logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt;
    logic enable_q;
    wire session_start = enable_req && !enable_q;
    wire wake_done = remote_active && backchannel_ok;

    always_comb begin
        next_state = state;
        case (state)
            SLBC_IDLE: if (session_start) next_state = remote_active ? SLBC_LOCKWAIT : SLBC_WAKE;
            SLBC_WAKE: begin
                if (!enable_req) next_state = SLBC_IDLE;
                else if (wake_done) next_state = SLBC_LOCKWAIT;
            end
            SLBC_LOCKWAIT: begin
                if (!enable_req) next_state = SLBC_IDLE;
                else if (rx_lock) next_state = SLBC_CHECK;
            end
            SLBC_CHECK: if (!enable_req) next_state = SLBC_DONE;
            SLBC_DONE: begin
                if (session_start) next_state = SLBC_WAKE;
                else if (!rx_lock) next_state = SLBC_IDLE;
            end
            default: next_state = SLBC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= SLBC_IDLE;
            enable_q <= 1'b0;
            wake_cnt <= '0;
        end else begin
            state <= next_state;
            enable_q <= enable_req;
            if (state == SLBC_WAKE && wake_cnt != WAKE_CYCLES[$bits(wake_cnt)-1:0])
                wake_cnt <= wake_cnt + 1'b1;
            else if (state != SLBC_WAKE)
                wake_cnt <= '0;
        end
    end

    wire checking = (state == SLBC_CHECK);
    assign remote_wake = (state == SLBC_WAKE);
    assign remote_selftest = (state == SLBC_WAKE) || (state == SLBC_LOCKWAIT) || checking;
    assign selftest_active = (state != SLBC_IDLE);
    assign video_normal = (state == SLBC_IDLE) || (state == SLBC_DONE);
    assign clock_source = slbc_clksrc_type'(sel_code);

    // frame buffer
    slbc_frame_type fifo_out;
    logic fifo_valid;
    logic fifo_flush;
    assign fifo_flush = (state == SLBC_IDLE);
    slbc_fifo #(.WIDTH($bits(slbc_frame_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_sync_b(rst_sync_b),
        .flush(fifo_flush),
        .in_valid(frame_valid && checking),
        .in_ready(frame_ready),
        .in_data(frame_in),
        .out_valid(fifo_valid),
        .out_ready(checking),
        .out_data(fifo_out)
    );
    // an errored frame is one whose end marker carries the sticky error
    logic frame_err;
    wire take = fifo_valid && checking;
    wire err_frame_end = take && fifo_out.frame_end && (frame_err || fifo_out.payload_error);

    // error counter and result
    logic [COUNT_WIDTH-1:0] err_count;
    logic run_failed;
    logic pulse_low;
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            frame_err <= 1'b0;
            err_count <= '0;
            run_failed <= 1'b0;
            pulse_low <= 1'b0;
        end else begin
            pulse_low <= err_frame_end;
            if (session_start) begin
                frame_err <= 1'b0;
                err_count <= '0;
                run_failed <= 1'b0;
            end else if (take) begin
                frame_err <= fifo_out.frame_end ? 1'b0 : (frame_err || fifo_out.payload_error);
                if (err_frame_end) begin
                    run_failed <= 1'b1;
                    if (err_count != {COUNT_WIDTH{1'b1}}) err_count <= err_count + 1'b1;
                end
            end
        end
    end

    // result high while checking, low pulse per errored frame, pass/fail after run
    logic result_q;
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) result_q <= 1'b0;
        else if (checking) result_q <= !err_frame_end;
        else if (state == SLBC_DONE) result_q <= !run_failed;
        else if (state != SLBC_DONE) result_q <= 1'b0;
    end
    assign result_pin = result_q;

    // register read
    wire [7:0] count_rd = 8'(err_count);
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_req.read && reg_req.addr == `SLBC_ADDR_CONTROL) reg_rdata = selftest_control;
        else if (reg_req.read && reg_req.addr == `SLBC_ADDR_ERROR_COUNT)
            reg_rdata = count_rd;
    end

    chk_pulse_one_cycle: assert property (@(posedge clk) disable iff (!rst_sync_b)
        pulse_low && $past(checking) |-> !result_pin ##1 !pulse_low || result_pin)
        else $error("result pulse not one cycle");
    chk_pulse_per_frame: assert property (@(posedge clk) disable iff (!rst_sync_b)
        checking && err_frame_end |=> !result_pin) else $error("no low pulse");
    chk_count_steps: assert property (@(posedge clk) disable iff (!rst_sync_b)
        err_frame_end && !session_start && err_count != {COUNT_WIDTH{1'b1}}
        |=> err_count == $past(err_count) + 1'b1) else $error("count not stepped");
    chk_count_clear: assert property (@(posedge clk) disable iff (!rst_sync_b)
        session_start |=> err_count == '0) else $error("count not cleared");
    chk_count_saturate: assert property (@(posedge clk) disable iff (!rst_sync_b)
        err_count == {COUNT_WIDTH{1'b1}} && !session_start |=> err_count == $past(err_count))
        else $error("count wrapped");
    chk_lock_start: assert property (@(posedge clk) disable iff (!rst_sync_b)
        state == SLBC_LOCKWAIT && rx_lock && enable_req |=> checking)
        else $error("check not started");
    chk_stop_check: assert property (@(posedge clk) disable iff (!rst_sync_b)
        checking && !enable_req |=> state == SLBC_DONE ##0 video_normal)
        else $error("check not stopped");
    chk_result_hold: assert property (@(posedge clk) disable iff (!rst_sync_b)
        state == SLBC_DONE && $past(state) == SLBC_DONE |-> result_pin == !run_failed)
        else $error("result not held");
    chk_wake_remote: assert property (@(posedge clk) disable iff (!rst_sync_b)
        state == SLBC_IDLE && session_start && !remote_active |=> remote_wake)
        else $error("no wake");
    chk_count_read: assert property (@(posedge clk) disable iff (!rst_sync_b)
        reg_req.read && reg_req.addr == `SLBC_ADDR_ERROR_COUNT |-> reg_rdata == count_rd)
        else $error("bad count read");
    chk_pin_source: assert property (@(posedge clk) disable iff (!rst_sync_b)
        !use_reg |-> clock_source == slbc_clksrc_type'(pin_sel))
        else $error("bad clock source");
endmodule : slbc_checker
`default_nettype wire

// *** src/slbc_defines.svh ***
// register offsets, field positions, reset values and timing counts of the self-test checker
`ifndef SLBC_DEFINES_SVH
`define SLBC_DEFINES_SVH
`define SLBC_ADDR_CONTROL 8'h24
`define SLBC_ADDR_ERROR_COUNT 8'h25
`define SLBC_CTL_PIN_OVERRIDE 0
`define SLBC_CTL_ENABLE 1
`define SLBC_CTL_CLKSEL_LO 2
`define SLBC_CTL_CLKSEL_HI 3
`define SLBC_CTL_RESET 8'h00
`define SLBC_COUNT_RESET 8'h00
`define SLBC_COUNT_MAX 8'hFF
`define SLBC_CLK_NS 10
`define SLBC_WAKE_NS 1000
`define SLBC_WAKE_CYCLES ((`SLBC_WAKE_NS + `SLBC_CLK_NS - 1) / `SLBC_CLK_NS)
`endif

// *** src/slbc_fifo.sv ***
// parameterised valid/ready FIFO
`timescale 1ns/100ps
`default_nettype none
module slbc_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_sync_b,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge clk) begin
        if (push) mem[wr_ptr[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : slbc_fifo
`default_nettype wire

// *** src/slbc_pkg.sv ***
// types of the self-test checker
package slbc_pkg;
    typedef enum logic [1:0] {
        SLBC_SRC_EXTERNAL = 2'b00,
        SLBC_SRC_INT_50 = 2'b01,
        SLBC_SRC_INT_25 = 2'b10,
        SLBC_SRC_INT_12P5 = 2'b11
    } slbc_clksrc_type;
    typedef enum logic [4:0] {
        SLBC_IDLE = 5'b00001,
        SLBC_WAKE = 5'b00010,
        SLBC_LOCKWAIT = 5'b00100,
        SLBC_CHECK = 5'b01000,
        SLBC_DONE = 5'b10000
    } slbc_state_type;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } slbc_reg_req_type;
    typedef struct packed {
        logic frame_end;
        logic payload_error;
    } slbc_frame_type;
endpackage : slbc_pkg
